// ---- src/agpp_pkg.sv ----
// Constants, register map and carrier types of the alarm pulse port
package agpp_pkg;

    // Clock and tick timing
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned MS_TICK_MS = 1;
    localparam int unsigned MS_TICK_CYCLES = (MS_TICK_MS * 1000000000) / CLK_PERIOD_PS;
    localparam int unsigned TICK_CNT_W = 18;

    // Pulse and pause settings in ms
    localparam int unsigned MS_W = 14;
    localparam logic [13:0] PULSE_MAX_MS = 14'd10000;
    localparam int unsigned REMAIN_W = 16;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LEVEL = 8'h04;
    localparam logic [7:0] REG_TOGGLE = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PULSE0 = 8'h10;
    localparam logic [7:0] REG_PAUSE0 = 8'h14;
    localparam logic [7:0] REG_PULSE1 = 8'h18;
    localparam logic [7:0] REG_PAUSE1 = 8'h1c;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_CLEAR = 8'h24;
    localparam logic [7:0] REG_IRQ_ENABLE = 8'h28;

    // Control field layout, one group per port
    localparam int unsigned CTRL_STRIDE = 4;
    localparam int unsigned CTRL_ACT_POS = 2;

    // Status field layout
    localparam int unsigned STAT_RF_POS = 2;
    localparam int unsigned STAT_ALARM_LSB = 3;

    // Interrupt bits
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_CHANGE_POS = 0;
    localparam int unsigned IRQ_ALARM_LSB = 1;

    // Reset values
    localparam logic [1:0] HOST_LEVEL_RST = 2'b11;
    localparam logic ACTIVE_HIGH_RST = 1'b1;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Port functions
    typedef enum logic [1:0] {MODE_GPIO, MODE_IN_TRIG, MODE_OUT_TRIG} agpp_mode_e;

    typedef struct packed {
        agpp_mode_e mode;
        logic activeHigh;
    } agpp_port_cfg_t;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } agpp_axi_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } agpp_axi_rsp_t;

endpackage

// ---- src/agpp_ms_tick.sv ----
// One-millisecond tick divider
`timescale 1ns/100ps
`default_nettype none
module agpp_ms_tick
    import agpp_pkg::*;
#(
    parameter int unsigned CYCLES = MS_TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    typedef struct packed {
        logic [TICK_CNT_W-1:0] count;
        logic tick;
    } agpp_tick_state_t;

    agpp_tick_state_t s;
    agpp_tick_state_t next_s;

    // Count cycles, pulse once per period
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.count == TICK_CNT_W'(CYCLES - 1))
        begin
            next_s.count = '0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.count = s.count + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;
endmodule
`default_nettype wire

// ---- src/agpp_pulse_timer.sv ----
// Alarm pulse and pause timer for one output-trigger port
`timescale 1ns/100ps
`default_nettype none
module agpp_pulse_timer
    import agpp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic msTick,
    input wire logic trigger,
    input wire logic [MS_W-1:0] pulseMs,
    input wire logic [MS_W-1:0] pauseMs,
    output logic active
);
    typedef enum logic [1:0] {TM_IDLE, TM_PULSE, TM_PAUSE} agpp_tm_phase_e;

    typedef struct packed {
        agpp_tm_phase_e phase;
        logic [REMAIN_W-1:0] remain;
        logic active;
    } agpp_tm_state_t;

    agpp_tm_state_t s;
    agpp_tm_state_t next_s;

    // Phase sequencing; a load of N+1 ms guarantees at least N ms
    always_comb
    begin
        logic [REMAIN_W:0] sum;
        sum = '0;
        next_s = s;
        if (!enable)
        begin
            next_s = '0;
        end
        else
        begin
            unique case (s.phase)
                TM_IDLE:
                begin
                    if (trigger && pulseMs != '0) // see RL6
                    begin
                        next_s.phase = TM_PULSE;
                        next_s.remain = REMAIN_W'(pulseMs) + 1'b1; // see RL8
                    end
                end
                TM_PULSE:
                begin
                    sum = {1'b0, s.remain};
                    if (trigger && pauseMs == '0)
                        sum = sum + (REMAIN_W + 1)'(pulseMs); // see RL9
                    if (sum[REMAIN_W])
                        sum = {1'b0, {REMAIN_W{1'b1}}};
                    next_s.remain = sum[REMAIN_W-1:0];
                    if (msTick)
                    begin
                        if (sum[REMAIN_W-1:0] <= REMAIN_W'(1))
                        begin
                            // Expiry: pause blocks detections, else rearm
                            next_s.phase = (pauseMs != '0) ? TM_PAUSE : TM_IDLE; // see RL10
                            next_s.remain = (pauseMs != '0) ? REMAIN_W'(pauseMs) + 1'b1 : '0;
                        end
                        else
                        begin
                            next_s.remain = sum[REMAIN_W-1:0] - 1'b1;
                        end
                    end
                end
                TM_PAUSE:
                begin
                    if (msTick)
                    begin
                        if (s.remain <= REMAIN_W'(1))
                        begin
                            next_s.phase = TM_IDLE; // see RL10
                            next_s.remain = '0;
                        end
                        else
                        begin
                            next_s.remain = s.remain - 1'b1;
                        end
                    end
                end
                default:
                begin
                    next_s.phase = TM_IDLE;
                    next_s.remain = '0;
                end
            endcase
        end
        next_s.active = (next_s.phase == TM_PULSE);
    end

    // Cleared timers after reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s <= '0; // see RL14
        else
            s <= next_s;
    end

    assign active = s.active;
endmodule
`default_nettype wire

// ---- src/agpp_top.sv ----
// Two-pin alarm and trigger port with AXI4-Lite registers
// Behaviour
// RL1 - Port one takes exactly one of three functions: host I/O, RF-gating input trigger or alarm output trigger.
// RL2 - Port two takes only host I/O or alarm output trigger, never the input trigger.
// RL3 - A port in host I/O mode has no automatic behaviour and follows only the host's level.
// RL4 - A host toggle request inverts that port's level, with an effect that depends on its function.
// RL5 - In input-trigger mode the RF field and detection run while the synced input equals the active level.
// RL6 - In output-trigger mode a surveillance-bit or family-id detection drives the port to its active level.
// RL7 - Each output-trigger port has pulse and pause settings from 0 to 10000 ms.
// RL8 - A detection holds the output active for at least the pulse width, then it returns inactive.
// RL9 - With zero pause each detection adds one pulse width, so repeated detections keep the output active.
// RL10 - With nonzero pause the output is forced inactive for the pause after each pulse, ignoring detections.
// RL11 - Any change of a port level raises a state-change event that carries the new port status.
// RL12 - The port status mask holds port one in bit 0 and port two in bit 1, one meaning high.
// RL13 - The trigger input passes two flip-flops, and timing comes from a one-millisecond tick.
// RL14 - Reset leaves both ports in host I/O mode, released inactive, with timers cleared.
`timescale 1ns/100ps
`default_nettype none
module agpp_top
    import agpp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire agpp_axi_req_t axiReq,
    output agpp_axi_rsp_t axiRsp,
    input wire logic surveillanceBitDetect,
    input wire logic familyIdDetect,
    input wire logic [1:0] gpioIn,
    output logic [1:0] gpioOut,
    output logic [1:0] gpioOe,
    output logic rfFieldEnable,
    output logic gpioEventValid,
    output logic [1:0] gpioEventMask,
    output logic irq
);
    typedef struct packed {
        agpp_axi_rsp_t rsp;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        agpp_port_cfg_t [1:0] cfg;
        logic [1:0] hostLevel;
        logic [1:0][MS_W-1:0] pulseMs;
        logic [1:0][MS_W-1:0] pauseMs;
        logic syncA;
        logic syncB;
        logic [1:0] portLevel;
        logic [1:0] pinOut;
        logic [1:0] pinOe;
        logic rfOn;
        logic [1:0] alarmPrev;
        logic [IRQ_W-1:0] irqStatus;
        logic [IRQ_W-1:0] irqEnable;
        logic irq;
        logic eventValid;
        logic [1:0] eventMask;
    } agpp_top_state_t;

    agpp_top_state_t s;
    agpp_top_state_t next_s;
    logic msTick;
    logic [1:0] alarmActive;
    logic detect;

    // Millisecond time base
    agpp_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(msTick) // see RL13
    );

    assign detect = surveillanceBitDetect | familyIdDetect;

    // One pulse timer per port
    for (genvar i = 0; i < 2; i++)
    begin : g_timer
        agpp_pulse_timer u_timer (
            .clk(clk),
            .rst(rst),
            .enable(s.cfg[i].mode == MODE_OUT_TRIG),
            .msTick(msTick),
            .trigger(detect),
            .pulseMs(s.pulseMs[i]),
            .pauseMs(s.pauseMs[i]),
            .active(alarmActive[i])
        );
    end

    // Register readback, error flag in bit 32
    function automatic logic [32:0] regRead(input agpp_top_state_t st, input logic [7:0] a,
                                            input logic [1:0] alarm);
        logic [32:0] r;
        r = '0;
        unique case (a[7:2])
            REG_CTRL[7:2]:
            begin
                for (int i = 0; i < 2; i++)
                begin
                    r[i*CTRL_STRIDE +: 2] = st.cfg[i].mode;
                    r[i*CTRL_STRIDE + CTRL_ACT_POS] = st.cfg[i].activeHigh;
                end
            end
            REG_LEVEL[7:2]: r[1:0] = st.hostLevel;
            REG_TOGGLE[7:2], REG_IRQ_CLEAR[7:2]: r = '0;
            REG_STATUS[7:2]:
            begin
                r[1:0] = st.portLevel; // see RL12
                r[STAT_RF_POS] = st.rfOn;
                r[STAT_ALARM_LSB +: 2] = alarm;
            end
            REG_PULSE0[7:2]: r[MS_W-1:0] = st.pulseMs[0];
            REG_PAUSE0[7:2]: r[MS_W-1:0] = st.pauseMs[0];
            REG_PULSE1[7:2]: r[MS_W-1:0] = st.pulseMs[1];
            REG_PAUSE1[7:2]: r[MS_W-1:0] = st.pauseMs[1];
            REG_IRQ_STATUS[7:2]: r[IRQ_W-1:0] = st.irqStatus;
            REG_IRQ_ENABLE[7:2]: r[IRQ_W-1:0] = st.irqEnable;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    // Setting limited to the documented range
    function automatic logic [MS_W-1:0] clampMs(input logic [31:0] v);
        return (v > 32'(PULSE_MAX_MS)) ? PULSE_MAX_MS : v[MS_W-1:0]; // see RL7
    endfunction

    // Whole next-state of bus slave and ports
    always_comb
    begin
        logic haveAw;
        logic haveW;
        logic [7:0] awA;
        logic [31:0] wD;
        logic [3:0] wS;
        logic [32:0] oldVal;
        logic [32:0] rdVal;
        logic [31:0] wrVal;
        logic [1:0] lvl;
        logic [1:0] mv;
        logic [IRQ_W-1:0] events;
        haveAw = 1'b0;
        haveW = 1'b0;
        awA = '0;
        wD = '0;
        wS = '0;
        oldVal = '0;
        rdVal = '0;
        wrVal = '0;
        lvl = '0;
        mv = '0;
        events = '0;
        next_s = s;

        // Write address and data, taken in either order
        haveAw = s.awHeld | (axiReq.awvalid & s.rsp.awready);
        haveW = s.wHeld | (axiReq.wvalid & s.rsp.wready);
        awA = s.awHeld ? s.awAddr : axiReq.awaddr;
        wD = s.wHeld ? s.wData : axiReq.wdata;
        wS = s.wHeld ? s.wStrb : axiReq.wstrb;
        if (s.rsp.bvalid && axiReq.bready)
            next_s.rsp.bvalid = 1'b0;
        if (haveAw && haveW && !s.rsp.bvalid)
        begin
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            oldVal = regRead(s, awA, alarmActive);
            next_s.rsp.bresp = oldVal[32] ? RESP_SLVERR : RESP_OKAY;
            for (int b = 0; b < 4; b++)
                wrVal[b*8 +: 8] = wS[b] ? wD[b*8 +: 8] : oldVal[b*8 +: 8];
            unique case (awA[7:2])
                REG_CTRL[7:2]:
                begin
                    for (int i = 0; i < 2; i++)
                    begin
                        mv = wrVal[i*CTRL_STRIDE +: 2];
                        // Illegal function codes leave the port unchanged
                        if (mv == MODE_GPIO || mv == MODE_OUT_TRIG || (i == 0 && mv == MODE_IN_TRIG)) // see RL1, RL2
                        begin
                            next_s.cfg[i].mode = agpp_mode_e'(mv);
                            next_s.cfg[i].activeHigh = wrVal[i*CTRL_STRIDE + CTRL_ACT_POS];
                        end
                    end
                end
                REG_LEVEL[7:2]: next_s.hostLevel = wrVal[1:0]; // see RL3
                REG_TOGGLE[7:2]: next_s.hostLevel = s.hostLevel ^ wrVal[1:0]; // see RL4
                REG_PULSE0[7:2]: next_s.pulseMs[0] = clampMs(wrVal);
                REG_PAUSE0[7:2]: next_s.pauseMs[0] = clampMs(wrVal);
                REG_PULSE1[7:2]: next_s.pulseMs[1] = clampMs(wrVal);
                REG_PAUSE1[7:2]: next_s.pauseMs[1] = clampMs(wrVal);
                REG_IRQ_CLEAR[7:2]: next_s.irqStatus = s.irqStatus & ~wrVal[IRQ_W-1:0];
                REG_IRQ_ENABLE[7:2]: next_s.irqEnable = wrVal[IRQ_W-1:0];
                default: next_s.irqEnable = s.irqEnable;
            endcase
        end
        else
        begin
            next_s.awHeld = haveAw;
            next_s.awAddr = awA;
            next_s.wHeld = haveW;
            next_s.wData = wD;
            next_s.wStrb = wS;
        end
        next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
        next_s.rsp.wready = !next_s.wHeld && !next_s.rsp.bvalid;

        // Read channel, answer one cycle after the address
        if (s.rsp.rvalid && axiReq.rready)
            next_s.rsp.rvalid = 1'b0;
        if (s.rsp.arready && axiReq.arvalid)
        begin
            rdVal = regRead(s, axiReq.araddr, alarmActive);
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rdata = rdVal[31:0];
            next_s.rsp.rresp = rdVal[32] ? RESP_SLVERR : RESP_OKAY;
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;

        // Trigger input synchroniser
        next_s.syncA = gpioIn[0]; // see RL13
        next_s.syncB = s.syncA;

        // RF field gating from port one
        if (s.cfg[0].mode == MODE_IN_TRIG)
            next_s.rfOn = (s.syncB == s.cfg[0].activeHigh); // see RL5
        else
            next_s.rfOn = 1'b1;

        // Port levels by function; open drain drives only the low level
        for (int i = 0; i < 2; i++)
        begin
            unique case (s.cfg[i].mode)
                MODE_GPIO: lvl[i] = s.hostLevel[i]; // see RL3
                MODE_IN_TRIG: lvl[i] = s.syncB; // see RL5
                MODE_OUT_TRIG: lvl[i] = alarmActive[i] ? s.cfg[i].activeHigh : !s.cfg[i].activeHigh; // see RL6
                default: lvl[i] = 1'b1;
            endcase
            next_s.pinOe[i] = (s.cfg[i].mode != MODE_IN_TRIG) && !lvl[i];
        end
        next_s.pinOut = '0;
        next_s.portLevel = lvl;

        // State-change event with the new mask
        next_s.eventValid = (lvl != s.portLevel); // see RL11
        if (lvl != s.portLevel)
            next_s.eventMask = lvl; // see RL12

        // Sticky interrupt bits, a set beats a clear
        events[IRQ_CHANGE_POS] = (lvl != s.portLevel); // see RL11
        events[IRQ_ALARM_LSB +: 2] = alarmActive & ~s.alarmPrev;
        next_s.alarmPrev = alarmActive;
        next_s.irqStatus = next_s.irqStatus | events;
        next_s.irq = |(next_s.irqStatus & next_s.irqEnable);
    end

    // State register with reset defaults
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.rsp.awready <= 1'b1;
            s.rsp.wready <= 1'b1;
            s.rsp.arready <= 1'b1;
            s.cfg[0] <= '{mode: MODE_GPIO, activeHigh: ACTIVE_HIGH_RST}; // see RL14
            s.cfg[1] <= '{mode: MODE_GPIO, activeHigh: ACTIVE_HIGH_RST}; // see RL14
            s.hostLevel <= HOST_LEVEL_RST; // see RL14
            s.portLevel <= HOST_LEVEL_RST;
            s.eventMask <= HOST_LEVEL_RST; // see RL12
            s.rfOn <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign axiRsp = s.rsp;
    assign gpioOut = s.pinOut;
    assign gpioOe = s.pinOe;
    assign rfFieldEnable = s.rfOn;
    assign gpioEventValid = s.eventValid;
    assign gpioEventMask = s.eventMask;
    assign irq = s.irq;
endmodule
`default_nettype wire

// ---- bench/agpp_checker_assertions.sv ----
// Port checker for the alarm pulse port
`timescale 1ns/100ps
`default_nettype none
module agpp_checker
    import agpp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MS_TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire agpp_axi_req_t axiReq,
    input wire agpp_axi_rsp_t axiRsp,
    input wire logic surveillanceBitDetect,
    input wire logic familyIdDetect,
    input wire logic [1:0] gpioIn,
    input wire logic [1:0] gpioOut,
    input wire logic [1:0] gpioOe,
    input wire logic rfFieldEnable,
    input wire logic gpioEventValid,
    input wire logic [1:0] gpioEventMask,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Bus handshakes
    chk_rd_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
        else $error("read answer missing");
    chk_rd_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
        else $error("read data not held");
    chk_rd_release: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid && axiRsp.arready)
        else $error("read not released");
    chk_wr_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
        |=> axiRsp.bvalid) else $error("write answer missing");
    chk_wr_busy: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write accepted while busy");
    // Open-drain pins only ever sink
    chk_out_sink: assert property (gpioOut == 2'b00)
        else $error("open drain data not low");
    // Port status events
    chk_event_new: assert property (gpioEventValid |-> gpioEventMask != $past(gpioEventMask))
        else $error("event without new status");
    chk_event_cause: assert property ($changed(gpioEventMask) |-> gpioEventValid)
        else $error("status change without event");
    chk_mask_port2: assert property ($changed(gpioOe[1]) |-> gpioEventMask[1] == !gpioOe[1])
        else $error("port two status bit wrong");
    // Main scenarios
    cover property (gpioEventValid);
    cover property ($fell(rfFieldEnable));
    cover property (axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR);
    cover property ($fell(gpioOe[1]));
endmodule
bind agpp_top agpp_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk(clk), .rst(rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .surveillanceBitDetect(surveillanceBitDetect), .familyIdDetect(familyIdDetect),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .rfFieldEnable(rfFieldEnable),
    .gpioEventValid(gpioEventValid), .gpioEventMask(gpioEventMask), .irq(irq));
`default_nettype wire

// ---- bench/agpp_field_model.sv ----
// Open-collector wiring with light barrier and alarm sounder
`timescale 1ns/100ps
`default_nettype none
module agpp_field_model
(
    input wire logic [1:0] gpioOe,
    input wire logic personPresent,
    output logic [1:0] gpioIn,
    output logic alarmOn
);
    // Pull-ups on both pins, barrier switch sinks pin one
    assign gpioIn = ~(gpioOe | {1'b0, personPresent});
    // Sounder wired for an active-high port two
    assign alarmOn = gpioIn[1];
endmodule
`default_nettype wire

// ---- bench/alarm_gpio_pulse_port_test.sv ----
// Self-checking bench for the alarm pulse port
`timescale 1ns/100ps
`default_nettype none
module alarm_gpio_pulse_port_test;
    import agpp_pkg::*;
    localparam int unsigned TICKS = 10;
    typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] data; logic [1:0] resp; logic [31:0] exp;} agpp_row_t;
    localparam agpp_row_t ROWS [10] = '{
        '{1'b0, REG_CTRL, 32'h0, RESP_OKAY, 32'h44}, '{1'b0, REG_LEVEL, 32'h0, RESP_OKAY, 32'h3},
        '{1'b0, REG_STATUS, 32'h0, RESP_OKAY, 32'h7}, '{1'b0, REG_PULSE0, 32'h0, RESP_OKAY, 32'h0},
        '{1'b1, REG_PULSE0, 32'h2711, RESP_OKAY, 32'h2710}, '{1'b1, REG_CTRL, 32'h47, RESP_OKAY, 32'h44},
        '{1'b1, REG_CTRL, 32'h10, RESP_OKAY, 32'h40}, '{1'b1, 8'h30, 32'h1, RESP_SLVERR, 32'h0},
        '{1'b0, REG_TOGGLE, 32'h0, RESP_OKAY, 32'h0}, '{1'b1, REG_PAUSE1, 32'h5, RESP_OKAY, 32'h5}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    agpp_axi_req_t axiReq = '0;
    agpp_axi_rsp_t axiRsp;
    logic survDet = 1'b0;
    logic famDet = 1'b0;
    logic personPresent = 1'b0;
    logic [1:0] gpioIn, gpioOe, gpioEventMask;
    logic rfFieldEnable, gpioEventValid, irq, alarmOn;
    logic [1:0] resp, wresp;
    logic [31:0] rd;
    int fail_count = 0;
    int num_checks = 0;
    int len;

    // Clock
    always #2 clk = ~clk;

    agpp_top #(.TICK_CYCLES(TICKS)) dut_u (.clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
        .surveillanceBitDetect(survDet), .familyIdDetect(famDet), .gpioIn(gpioIn), .gpioOut(),
        .gpioOe(gpioOe), .rfFieldEnable(rfFieldEnable), .gpioEventValid(gpioEventValid),
        .gpioEventMask(gpioEventMask), .irq(irq));
    agpp_field_model field_u (.gpioOe(gpioOe), .personPresent(personPresent), .gpioIn(gpioIn), .alarmOn(alarmOn));

    // Verdict and end of run
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    // Bus write, both channels offered together
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hf;
        axiReq.bready <= 1'b1;
        for (n = 0; !(axiReq.bready && axiRsp.bvalid); n++)
        begin
            @(posedge clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
        end
        check(n < 100, "write hang");
        r = axiRsp.bresp;
        axiReq.bready <= 1'b0;
    endtask

    // Bus read, ready offered with the address
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        for (n = 0; !(axiReq.rready && axiRsp.rvalid); n++)
        begin
            @(posedge clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
        end
        check(n < 100, "read hang");
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
    endtask

    // One-cycle detection from either source
    task automatic fire(input logic which);
        @(posedge clk);
        if (which) famDet <= 1'b1;
        else survDet <= 1'b1;
        @(posedge clk);
        famDet <= 1'b0;
        survDet <= 1'b0;
    endtask

    // Length of the next alarm, optional retrigger
    task automatic measure(input int retrigAt, output int n);
        int w;
        n = 0;
        for (w = 0; w < 20 && !alarmOn; w++) @(posedge clk);
        while (alarmOn && n < 2000)
        begin
            @(posedge clk);
            famDet <= (n == retrigAt);
            n++;
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(gpioOe === 2'b00 && rfFieldEnable === 1'b1 && irq === 1'b0, "reset outputs");
        foreach (ROWS[i])
        begin
            wresp = ROWS[i].resp;
            if (ROWS[i].wr) axi_write(ROWS[i].addr, ROWS[i].data, wresp);
            axi_read(ROWS[i].addr, rd, resp);
            check(wresp === ROWS[i].resp && resp === ROWS[i].resp && rd === ROWS[i].exp, "register row");
        end
        axi_write(REG_IRQ_CLEAR, 32'h7, resp);
        axi_write(REG_IRQ_ENABLE, 32'h1, resp);
        axi_write(REG_LEVEL, 32'h2, resp);
        repeat (3) @(posedge clk);
        check(gpioOe === 2'b01 && gpioEventMask === 2'b10 && irq === 1'b1, "host level");
        axi_write(REG_TOGGLE, 32'h3, resp);
        repeat (3) @(posedge clk);
        check(gpioOe === 2'b10 && gpioEventMask === 2'b01, "toggle");
        axi_write(REG_IRQ_ENABLE, 32'h0, resp);
        axi_write(REG_TOGGLE, 32'h2, resp);
        repeat (3) @(posedge clk);
        check(irq === 1'b0 && gpioOe === 2'b00, "masked event");
        axi_read(REG_IRQ_STATUS, rd, resp);
        check(rd[0] === 1'b1, "sticky change bit");
        axi_write(REG_IRQ_CLEAR, 32'h1, resp);
        axi_read(REG_IRQ_STATUS, rd, resp);
        check(rd[0] === 1'b0, "change bit cleared");
        axi_write(REG_CTRL, 32'h41, resp);
        repeat (5) @(posedge clk);
        check(rfFieldEnable === 1'b0, "field off while idle");
        personPresent <= 1'b1;
        repeat (2) @(posedge clk);
        check(rfFieldEnable === 1'b0, "input synchronised");
        repeat (3) @(posedge clk);
        check(rfFieldEnable === 1'b1, "field on at active level");
        personPresent <= 1'b0;
        axi_write(REG_PULSE1, 32'h3, resp);
        axi_write(REG_PAUSE1, 32'h0, resp);
        axi_write(REG_CTRL, 32'h64, resp);
        fire(1'b0);
        measure(-1, len);
        check(len >= 29 && len <= 42, "pulse width");
        fire(1'b1);
        measure(20, len);
        check(len >= 59 && len <= 72, "retrigger");
        axi_write(REG_PAUSE1, 32'h5, resp);
        fire(1'b0);
        measure(-1, len);
        fire(1'b1);
        measure(-1, len);
        check(len === 0, "pause holds off");
        axi_write(REG_CTRL, 32'h66, resp);
        repeat (60) @(posedge clk);
        fire(1'b0);
        measure(-1, len);
        check(len >= 29 && len <= 42, "pulse after pause");
        axi_read(REG_STATUS, rd, resp);
        check(rd === 32'hd && gpioOe === 2'b10, "port one alarm");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(gpioOe === 2'b00 && rfFieldEnable === 1'b1 && irq === 1'b0, "mid-run reset");
        complete_run();
    end

    // Watchdog
    initial
    begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
